// *** bench/i2csa_assertions.sv ***
/*
  Port checker for the address select and soft reset slave.
  Assumes one clock domain and the bench holds nvm_data_i steady.
*/
`timescale 1ns/100ps
module i2csa_chk
  import i2csa_pkg::*;
#(
  parameter int unsigned POR_COUNT = POR_CYC
) (
  input wire logic                   clk_sys_i,
  input wire logic                   rst_n_i,
  input wire logic                   scl_i,
  input wire logic                   sda_o,
  input wire logic                   sda_oe_n_o,
  input wire logic [NREG*REG_W-1:0]  nvm_data_i,
  input wire logic [NREG*REG_W-1:0]  regs_o,
  input wire logic                   busy_o
);
  int busy_cnt_reg;
  int busy_cnt_next;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  always_comb begin
    busy_cnt_next = busy_o ? busy_cnt_reg + 1 : 0;
  end
  always_ff @(posedge clk_sys_i) begin
    busy_cnt_reg <= busy_cnt_next;
  end
  property p_sda_low; sda_o == 1'b0; endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda data not low");
  property p_sda_steady; scl_i && $past(scl_i) |-> $stable(sda_oe_n_o); endproperty
  a_sda_steady: assert property (p_sda_steady) else $error("sda moved with scl high");
  property p_rst_busy; $rose(rst_n_i) |-> busy_o; endproperty
  a_rst_busy: assert property (p_rst_busy) else $error("no busy after reset");
  property p_rst_clear; $rose(rst_n_i) |-> sda_oe_n_o && regs_o == '0; endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("state not cleared");
  property p_ack_start; $fell(sda_oe_n_o) |-> !scl_i; endproperty
  a_ack_start: assert property (p_ack_start) else $error("ack starts with scl high");
  property p_ack_end; $rose(sda_oe_n_o) && !busy_o |-> !scl_i; endproperty
  a_ack_end: assert property (p_ack_end) else $error("ack ends with scl high");
  property p_quiet; busy_o && $past(busy_o, 3) |-> sda_oe_n_o; endproperty
  a_quiet: assert property (p_quiet) else $error("sda driven while busy");
  property p_reload; $fell(busy_o) |-> ##[1:3] regs_o == nvm_data_i; endproperty
  a_reload: assert property (p_reload) else $error("registers not reloaded");
  property p_por_len; $fell(busy_o) |-> busy_cnt_reg >= POR_COUNT; endproperty
  a_por_len: assert property (p_por_len) else $error("power-on sequence short");
  c_ack: cover property ($fell(sda_oe_n_o));
  c_soft: cover property ($rose(busy_o));
  c_done: cover property ($fell(busy_o));
endmodule

bind i2csa_top i2csa_chk #(.POR_COUNT(POR_COUNT)) u_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .nvm_data_i(nvm_data_i), .regs_o(regs_o), .busy_o(busy_o));

// *** bench/i2csa_master.sv ***
/*
  Behavioural bus master, driving at the falling clock edge.
  Assumes sda_line_i is the resolved wire with a pull-up.
*/
`timescale 1ns/100ps
module i2csa_master (
  input  wire logic clk_sys_i,
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wq();
    repeat (5) @(negedge clk_sys_i);
  endtask
  task automatic start();
    sda_o = 1'b0;
    wq();
    scl_o = 1'b0;
    wq();
  endtask
  task automatic stop();
    sda_o = 1'b0;
    wq();
    scl_o = 1'b1;
    wq();
    sda_o = 1'b1;
    wq();
  endtask
  task automatic put(input logic v, output logic s);
    sda_o = v;
    wq();
    scl_o = 1'b1;
    wq();
    s = sda_line_i;
    wq();
    scl_o = 1'b0;
    wq();
  endtask
  // Address or data byte, MSB first, then ack slot
  task automatic xfer(input logic [7:0] b, output logic ak);
    for (int i = 7; i >= 0; i--) put(b[i], ak);
    put(1'b1, ak);
    ak = !ak;
  endtask
endmodule

// *** bench/testbench.sv ***
/*
  Random self-checking bench for the slave address select and soft reset.
  Assumes the master model in i2csa_master and the bound port checker.
*/
`timescale 1ns/100ps
module testbench
  import i2csa_pkg::*;
;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, sda_drv, scl, sda_o, sda_oe_n, busy, ak, seen;
  logic [3:0] sel_pins, use_pin, pf;
  logic [7:0] dt;
  logic [31:0] nvm, regs;
  i2csa_cfg_t cfg;
  int seed, n_mismatch, checks;
  wire logic sda_line = sda_drv & (sda_oe_n | sda_o);
  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge busy) seen = rst_n_i;
  i2csa_master u_mst (.clk_sys_i(clk_sys_i), .sda_line_i(sda_line), .scl_o(scl), .sda_o(sda_drv));
  i2csa_top #(.POR_COUNT(4)) u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .cfg_i(cfg),
    .addr_sel_i(sel_pins), .sel_use_pin_i(use_pin), .nvm_data_i(nvm), .regs_o(regs),
    .busy_o(busy));
  function automatic logic [3:0] exp_pfx(i2csa_cfg_t c, logic [3:0] p, logic [3:0] u);
    for (int i = 0; i < 4; i++) exp_pfx[i] = (c.ext_en && u[i]) ? p[i] : c.cfg_prefix[i];
  endfunction
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] p, logic [7:0] d, output logic a);
    logic a2;
    u_mst.start();
    u_mst.xfer(ad, a);
    if (a) begin
      u_mst.xfer(p, a2);
      u_mst.xfer(d, a2);
    end
    u_mst.stop();
  endtask
  task automatic wait_busy(logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 300) begin
      @(negedge clk_sys_i);
      n++;
    end
    repeat (4) @(negedge clk_sys_i);
    chk("busy", 32'(lvl), 32'(busy));
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    n_mismatch++;
    conclude();
  end
  initial begin
    seed = 73372;
    cfg = '0;
    sel_pins = 4'h0;
    use_pin = 4'h0;
    seen = 1'b0;
    nvm = $random(seed) & 32'hffff_fffe;
    repeat (10) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    wait_busy(1'b0);
    chk("regs", nvm, regs);
    for (int i = 0; i < 16; i++) begin
      cfg = i2csa_cfg_t'(5'($random(seed)));
      sel_pins = 4'($random(seed));
      use_pin = 4'($random(seed));
      if (i < 2) begin
        cfg.ext_en = i[0];
        use_pin = 4'hf;
      end
      pf = i[0] ? exp_pfx(cfg, sel_pins, use_pin) : 4'($random(seed));
      dt = 8'($random(seed)) & 8'hfe;
      wr({pf, 4'h0}, 8'h01, dt, ak);
      chk("ack", 32'(pf == exp_pfx(cfg, sel_pins, use_pin)), 32'(ak));
      if (ak) chk("reg1", 32'(dt), 32'(regs[15:8]));
    end
    cfg.ext_en = 1'b0;
    wr({cfg.cfg_prefix, 4'h0}, 8'h00, 8'h01, ak);
    wait_busy(1'b0);
    chk("soft", 32'h1, 32'(seen));
    chk("regs", nvm, regs);
    conclude();
  end
endmodule

// *** design/i2csa_por.sv ***
/*
  Power-on sequencer: holds the core in reset for a fixed count after
  external reset or a soft reset request, and flags the NVM reload.
  Assumes a synchronous active-low reset and a one-cycle request pulse.
*/
`timescale 1ns/100ps
module i2csa_por
  import i2csa_pkg::*;
#(
  parameter int unsigned POR_COUNT = POR_CYC
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // Request and status
  input  wire logic soft_req_i,
  output logic      core_rst_n_o,
  output logic      reload_o
);
  logic [POR_W-1:0] cnt_reg;
  logic [POR_W-1:0] cnt_next;
  logic             busy_reg;
  logic             busy_next;
  logic             reload_reg;
  logic             reload_next;

  always_comb begin
    cnt_next    = cnt_reg;
    busy_next   = busy_reg;
    reload_next = 1'b0;
    if (soft_req_i) begin
      cnt_next  = '0;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == POR_W'(POR_COUNT - 1)) begin
        busy_next   = 1'b0;
        reload_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + POR_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt_reg    <= '0;
      busy_reg   <= 1'b1;
      reload_reg <= 1'b0;
    end else begin
      cnt_reg    <= cnt_next;
      busy_reg   <= busy_next;
      reload_reg <= reload_next;
    end
  end

  assign core_rst_n_o = ~busy_reg;
  assign reload_o     = reload_reg;
endmodule

// *** design/i2csa_top.sv ***
/*
  Serial slave with selectable address prefix and soft reset.
  Assumes SCL/SDA sampled synchronously at 25 MHz, far slower bus clock,
  and an NVM image presented on nvm_data_i.
*/
`timescale 1ns/100ps
module i2csa_top
  import i2csa_pkg::*;
#(
  parameter logic [LOW_W-1:0] LOW_ADDR  = 3'h0,
  parameter int unsigned      POR_COUNT = POR_CYC
) (
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  // Serial bus
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_n_o,
  // Address configuration
  input  wire i2csa_cfg_t           cfg_i,
  input  wire logic [PFX_W-1:0]     addr_sel_i,
  input  wire logic [PFX_W-1:0]     sel_use_pin_i,
  // Non-volatile image
  input  wire logic [NREG*REG_W-1:0] nvm_data_i,
  // Register contents and state
  output logic [NREG*REG_W-1:0]     regs_o,
  output logic                      busy_o
);
  i2csa_line_t  line_reg, line_next;
  i2csa_state_t st_reg, st_next;
  logic [BIT_CNT_W-1:0]  bit_reg, bit_next;
  logic [REG_W-1:0]      sh_reg, sh_next;
  logic [IDX_W-1:0]      ptr_reg, ptr_next;
  logic                  rd_reg, rd_next;
  logic                  oe_n_reg, oe_n_next;
  logic [REG_W-1:0]      mem_reg [NREG];
  logic [REG_W-1:0]      mem_next [NREG];
  logic [NREG*REG_W-1:0] regs_reg, regs_next;
  logic                  soft_req_reg, soft_req_next;
  logic                  busy_reg;
  logic                  core_rst_n;
  logic                  reload;
  logic [PFX_W-1:0]      prefix;
  logic                  scl_rise, scl_fall, start_c, stop_c;

  function automatic logic [PFX_W-1:0] pick_prefix(input i2csa_cfg_t c,
                                                   input logic [PFX_W-1:0] pins,
                                                   input logic [PFX_W-1:0] use_pin);
    logic [PFX_W-1:0] p;
    p = c.cfg_prefix;
    if (c.ext_en) begin
      for (int i = 0; i < PFX_W; i++) begin
        if (use_pin[i]) begin
          p[i] = pins[i];
        end
      end
    end
    return p;
  endfunction

  i2csa_por #(
    .POR_COUNT (POR_COUNT)
  ) u_por (
    .clk_sys_i    (clk_sys_i),
    .rst_n_i      (rst_n_i),
    .soft_req_i   (soft_req_reg),
    .core_rst_n_o (core_rst_n),
    .reload_o     (reload)
  );

  assign prefix   = pick_prefix(cfg_i, addr_sel_i, sel_use_pin_i);
  assign scl_rise = ~line_reg.scl & scl_i;
  assign scl_fall = line_reg.scl & ~scl_i;
  assign start_c  = line_reg.scl & scl_i & line_reg.sda & ~sda_i;
  assign stop_c   = line_reg.scl & scl_i & ~line_reg.sda & sda_i;

  always_comb begin
    line_next     = '{scl: scl_i, sda: sda_i};
    st_next       = st_reg;
    bit_next      = bit_reg;
    sh_next       = sh_reg;
    ptr_next      = ptr_reg;
    rd_next       = rd_reg;
    oe_n_next     = oe_n_reg;
    soft_req_next = 1'b0;
    for (int i = 0; i < NREG; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (reload) begin
      for (int i = 0; i < NREG; i++) begin
        mem_next[i] = nvm_data_i[i*REG_W +: REG_W];
      end
    end
    if (start_c) begin
      st_next   = I2CSA_ADDR;
      bit_next  = '0;
      oe_n_next = 1'b1;
    end else if (stop_c) begin
      st_next   = I2CSA_IDLE;
      oe_n_next = 1'b1;
    end else begin
      case (st_reg)
        I2CSA_IDLE: begin
          oe_n_next = 1'b1;
        end
        I2CSA_ADDR, I2CSA_PTR, I2CSA_DATA: begin
          if (rd_reg && st_reg == I2CSA_DATA) begin
            if (scl_fall) begin
              if (bit_reg == BITS_BYTE) begin
                oe_n_next = 1'b1;
                st_next   = I2CSA_DACK;
              end else begin
                oe_n_next = sh_reg[REG_W-1];
                sh_next   = {sh_reg[REG_W-2:0], 1'b0};
                bit_next  = bit_reg + BIT_CNT_W'(1);
              end
            end
          end else if (scl_rise) begin
            sh_next  = {sh_reg[REG_W-2:0], sda_i};
            bit_next = bit_reg + BIT_CNT_W'(1);
          end else if (scl_fall && bit_reg == BITS_BYTE) begin
            bit_next = '0;
            if (st_reg == I2CSA_ADDR) begin
              if (sh_reg[REG_W-1 -: PFX_W] == prefix &&
                  sh_reg[LOW_W:1] == LOW_ADDR) begin
                oe_n_next = 1'b0;
                rd_next   = sh_reg[0];
                st_next   = I2CSA_AACK;
              end else begin
                oe_n_next = 1'b1;
                st_next   = I2CSA_IDLE;
              end
            end else begin
              oe_n_next = 1'b0;
              if (st_reg == I2CSA_PTR) begin
                ptr_next = sh_reg[IDX_W-1:0];
              end else begin
                mem_next[ptr_reg] = sh_reg;
                if (ptr_reg == RST_IDX && sh_reg[RST_BIT]) begin
                  soft_req_next = 1'b1;
                end
                ptr_next = ptr_reg + IDX_W'(1);
              end
              // Pointer and data bytes share the data ack slot
              st_next = I2CSA_DACK;
              rd_next = 1'b0;
            end
          end
        end
        I2CSA_AACK, I2CSA_DACK: begin
          if (scl_fall) begin
            oe_n_next = 1'b1;
            bit_next  = '0;
            if (rd_reg) begin
              sh_next   = mem_reg[ptr_reg];
              ptr_next  = ptr_reg + IDX_W'(1);
              oe_n_next = mem_reg[ptr_reg][REG_W-1];
              sh_next   = {mem_reg[ptr_reg][REG_W-2:0], 1'b0};
              bit_next  = BIT_CNT_W'(1);
              st_next   = I2CSA_DATA;
            end else begin
              // Address ack leads to the pointer byte, later acks to data
              st_next = (st_reg == I2CSA_AACK) ? I2CSA_PTR : I2CSA_DATA;
            end
          end else if (scl_rise && rd_reg && st_reg == I2CSA_DACK && sda_i) begin
            rd_next = 1'b0;
            st_next = I2CSA_IDLE;
          end
        end
        default: begin
          st_next = I2CSA_IDLE;
        end
      endcase
    end
    for (int i = 0; i < NREG; i++) begin
      regs_next[i*REG_W +: REG_W] = mem_next[i];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !core_rst_n) begin
      line_reg     <= '{scl: 1'b1, sda: 1'b1};
      st_reg       <= I2CSA_IDLE;
      bit_reg      <= '0;
      sh_reg       <= '0;
      ptr_reg      <= '0;
      rd_reg       <= 1'b0;
      oe_n_reg     <= 1'b1;
      soft_req_reg <= 1'b0;
      regs_reg     <= '0;
      for (int i = 0; i < NREG; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      line_reg     <= line_next;
      st_reg       <= st_next;
      bit_reg      <= bit_next;
      sh_reg       <= sh_next;
      ptr_reg      <= ptr_next;
      rd_reg       <= rd_next;
      oe_n_reg     <= oe_n_next;
      soft_req_reg <= soft_req_next;
      regs_reg     <= regs_next;
      for (int i = 0; i < NREG; i++) begin
        mem_reg[i] <= mem_next[i];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b1;
    end else begin
      busy_reg <= ~core_rst_n;
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe_n_o = oe_n_reg;
  assign regs_o     = regs_reg;
  assign busy_o     = busy_reg;
endmodule

// *** inc/i2csa_pkg.sv ***
/*
  Package for the serial slave address select and soft reset block:
  bus constants, address fields, state and carrier types.
  Assumes a single 25 MHz system clock and oversampled SCL/SDA inputs.
*/
package i2csa_pkg;
  localparam int unsigned PFX_W      = 4;
  localparam int unsigned LOW_W      = 3;
  localparam int unsigned REG_W      = 8;
  localparam int unsigned NREG       = 4;
  localparam int unsigned IDX_W      = 2;
  localparam int unsigned BIT_CNT_W  = 4;
  localparam logic [3:0]  BITS_BYTE  = 4'h8;
  localparam logic [3:0]  BIT_ACK    = 4'h9;
  // Soft reset bit: register index and bit position
  localparam logic [IDX_W-1:0] RST_IDX = 2'h0;
  localparam int unsigned      RST_BIT = 0;
  // Power-on sequence length in system cycles
  localparam int unsigned POR_NS     = 1000;
  localparam int unsigned CLK_NS     = 40;
  localparam int unsigned POR_CYC    = (POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned POR_W      = 8;

  typedef enum logic [5:0] {
    I2CSA_IDLE  = 6'b000001,
    I2CSA_ADDR  = 6'b000010,
    I2CSA_AACK  = 6'b000100,
    I2CSA_PTR   = 6'b001000,
    I2CSA_DATA  = 6'b010000,
    I2CSA_DACK  = 6'b100000
  } i2csa_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2csa_line_t;

  typedef struct packed {
    logic                  ext_en;
    logic [PFX_W-1:0]      cfg_prefix;
  } i2csa_cfg_t;
endpackage
